// ===== src/tscu_params.svh
// Offsets, opcodes, sensor codes, reset values and timing figures of the command unit
`ifndef TSCU_PARAMS_SVH
`define TSCU_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define TSCU_OFS_CMD        8'h00
`define TSCU_OFS_STATUS     8'h04
`define TSCU_OFS_CFG_CHAN   8'h08
`define TSCU_OFS_CFG_TYPE   8'h0c
`define TSCU_OFS_CFG_LIMIT  8'h10
`define TSCU_OFS_CTRL       8'h14

// Status, command and control field positions
`define TSCU_ST_ALARM       0
`define TSCU_ST_RSP_READY   1
`define TSCU_ST_BUSY        2
`define TSCU_ST_MODE50      3
`define TSCU_ST_FAST        4
`define TSCU_CMD_RSP_VALID  8
`define TSCU_CTRL_SOFT_RST  0

// Command bytes
`define TSCU_OP_ALARM_BASE  8'h6c
`define TSCU_OP_REJECT50    8'h64
`define TSCU_OP_EXTENDED    8'he0
`define TSCU_OP_CAL_BASE    8'hc0
`define TSCU_EXT_FAST       8'h08
`define TSCU_EXT_VERSION    8'h05
`define TSCU_EXT_IDENT      8'h04
`define TSCU_EXT_TAIL       8'h00
`define TSCU_CAL_ACK        8'h00

// Calibration span codes
`define TSCU_SPAN_5V        8'h00
`define TSCU_SPAN_500MV     8'h01

// Sensor definition codes
`define TSCU_TYPE_V100M     8'h17
`define TSCU_TYPE_V500M     8'h16
`define TSCU_TYPE_V5        8'h15
`define TSCU_TYPE_V5_LEGACY 8'h00
`define TSCU_TYPE_TC_B      8'h24
`define TSCU_TYPE_TC_C      8'h23
`define TSCU_TYPE_TC_E      8'h01
`define TSCU_TYPE_TC_J      8'h1b
`define TSCU_TYPE_TC_K      8'h1c
`define TSCU_TYPE_TC_N      8'h22
`define TSCU_TYPE_TC_T      8'h1d
`define TSCU_TYPE_TC_S      8'h1e
`define TSCU_TYPE_TC_R      8'h1f
`define TSCU_TYPE_LOOP      8'h11
`define TSCU_TYPE_DISABLED  8'h13

// Reset values
`define TSCU_LIMIT_LO_RST   16'h8000
`define TSCU_LIMIT_HI_RST   16'h7fff
`define TSCU_TYPE_RST       8'h00

// Timing: clock rate and times in microseconds
`define TSCU_CLK_MHZ        10
`define TSCU_T_INTEG60_US   16700
`define TSCU_T_INTEG50_US   20000
`define TSCU_T_CHAN_DEF_US  22000
`define TSCU_T_CHAN_FAST_US 9000

`endif

// ===== src/tscu_pkg.sv
// Types shared by the thermo scanner command unit
package tscu_pkg;

  typedef enum logic [1:0] {
    TSCU_ST_IDLE = 2'b00,
    TSCU_ST_EXT  = 2'b01,
    TSCU_ST_CAL  = 2'b10
  } tscu_state_t;

  typedef enum logic [2:0] {
    TSCU_SC_V5UV     = 3'b000,
    TSCU_SC_V20UV    = 3'b001,
    TSCU_SC_V200UV   = 3'b010,
    TSCU_SC_V500UV   = 3'b011,
    TSCU_SC_TC_0P1C  = 3'b100,
    TSCU_SC_LOOP     = 3'b101,
    TSCU_SC_DISABLED = 3'b110,
    TSCU_SC_UNKNOWN  = 3'b111
  } tscu_scale_t;

  typedef enum logic {
    TSCU_SPAN_5V    = 1'b0,
    TSCU_SPAN_500MV = 1'b1
  } tscu_span_t;

endpackage : tscu_pkg

// ===== src/tscu_top.sv
// Thermo scanner command unit: byte command interpreter behind an Avalon-MM slave
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "tscu_params.svh"

module tscu_top #(
  parameter int             NUM_CHAN      = 32,
  parameter logic [15:0]    VERSION_X100  = 16'h0064,
  parameter logic [15:0]    PRODUCT_ID    = 16'h5a5a, // Arbitrary value
  parameter int             INTEG60_CYC   = `TSCU_T_INTEG60_US * `TSCU_CLK_MHZ,
  parameter int             INTEG50_CYC   = `TSCU_T_INTEG50_US * `TSCU_CLK_MHZ,
  parameter int             CHAN_DEF_CYC  = `TSCU_T_CHAN_DEF_US * `TSCU_CLK_MHZ,
  parameter int             CHAN_FAST_CYC = `TSCU_T_CHAN_FAST_US * `TSCU_CLK_MHZ
) (
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RSTN,
  input  wire logic [7:0]         I_AVS_ADDRESS,
  input  wire logic               I_AVS_READ,
  input  wire logic               I_AVS_WRITE,
  input  wire logic [31:0]        I_AVS_WRITEDATA,
  input  wire logic [3:0]         I_AVS_BYTEENABLE,
  output logic      [31:0]        O_AVS_READDATA,
  output logic                    O_AVS_WAITREQUEST,
  input  wire logic               I_SMP_VALID,
  input  wire logic [4:0]         I_SMP_CHAN,
  input  wire logic [15:0]        I_SMP_DATA,
  output logic                    O_SMP_VALID,
  output logic      [4:0]         O_SMP_CHAN,
  output logic      [15:0]        O_SMP_DATA,
  output tscu_pkg::tscu_scale_t   O_SMP_SCALE,
  output logic      [31:0]        O_SCAN_MASK,
  output logic                    O_MODE_50HZ,
  output logic                    O_MODE_FAST,
  output logic      [17:0]        O_INTEG_CYCLES,
  output logic      [17:0]        O_CHAN_CYCLES,
  output logic                    O_CAL_STB,
  output logic      [4:0]         O_CAL_CHAN,
  output tscu_pkg::tscu_span_t    O_CAL_SPAN,
  output logic      [15:0]        O_CAL_VALUE
);

  // Refuse parameter values the fixed-width logic cannot carry
  if (NUM_CHAN != 32)
    $error("tscu_top: NUM_CHAN must be 32");
  if (INTEG60_CYC > 262143 || INTEG50_CYC > 262143 || CHAN_DEF_CYC > 262143 ||
      CHAN_FAST_CYC > 262143 || INTEG60_CYC < 1 || INTEG50_CYC < 1 ||
      CHAN_DEF_CYC < 1 || CHAN_FAST_CYC < 1)
    $error("tscu_top: cycle counts must lie in 1 to 262143");

  // Sensor code to scale class
  function automatic tscu_pkg::tscu_scale_t scale_of(input logic [7:0] code);
    case (code)
      `TSCU_TYPE_V100M:     scale_of = tscu_pkg::TSCU_SC_V5UV;
      `TSCU_TYPE_V500M:     scale_of = tscu_pkg::TSCU_SC_V20UV;
      `TSCU_TYPE_V5:        scale_of = tscu_pkg::TSCU_SC_V200UV;
      `TSCU_TYPE_V5_LEGACY: scale_of = tscu_pkg::TSCU_SC_V500UV;
      `TSCU_TYPE_TC_B, `TSCU_TYPE_TC_C, `TSCU_TYPE_TC_E,
      `TSCU_TYPE_TC_J, `TSCU_TYPE_TC_K, `TSCU_TYPE_TC_N,
      `TSCU_TYPE_TC_T, `TSCU_TYPE_TC_S, `TSCU_TYPE_TC_R:
                            scale_of = tscu_pkg::TSCU_SC_TC_0P1C;
      `TSCU_TYPE_LOOP:      scale_of = tscu_pkg::TSCU_SC_LOOP;
      `TSCU_TYPE_DISABLED:  scale_of = tscu_pkg::TSCU_SC_DISABLED;
      default:              scale_of = tscu_pkg::TSCU_SC_UNKNOWN;
    endcase
  endfunction : scale_of

  // Byte-lane merge for limit register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++)
      if (be[k])
        r[8*k +: 8] = new_v[8*k +: 8];
    be_merge = r;
  endfunction : be_merge

  logic                  wreq_reg;
  logic [31:0]           rdata_reg;
  logic                  soft_rst_reg;
  logic                  board_rstn;
  tscu_pkg::tscu_state_t st_reg;
  logic [1:0]            idx_reg;
  logic [7:0]            arg_reg;
  logic [4:0]            cal_chan_reg;
  logic [7:0]            cal_span_reg;
  logic [7:0]            rsp0_reg;
  logic [7:0]            rsp1_reg;
  logic [1:0]            rsp_cnt_reg;
  logic                  mode50_reg;
  logic                  fast_reg;
  logic                  alarm_reg;
  logic [31:0]           up_flag_reg;
  logic [31:0]           lo_flag_reg;
  logic [4:0]            cfg_chan_reg;
  logic [7:0]            type_reg   [32];
  logic signed [15:0]    hi_lim_reg [32];
  logic signed [15:0]    lo_lim_reg [32];
  logic                  acc;
  logic                  rd_first;
  logic                  wr_cmd;
  logic                  rd_pop;
  logic                  wr_type;
  logic                  wr_limit;
  logic [7:0]            cb;
  logic                  do_alarm;
  logic                  do_50;
  logic                  do_fast;
  logic [31:0]           clr_mask;
  logic                  smp_live;
  logic                  smp_up;
  logic                  smp_lo;
  logic [31:0]           limit_wdata;

  // One wait state per access; effects land on the edge waitrequest is seen low
  assign acc      = (I_AVS_READ | I_AVS_WRITE) & ~wreq_reg;
  assign rd_first = I_AVS_READ & wreq_reg;
  assign cb       = I_AVS_WRITEDATA[7:0];
  assign wr_cmd   = acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0] &
                    (I_AVS_ADDRESS == `TSCU_OFS_CMD);
  assign rd_pop   = acc & I_AVS_READ & (I_AVS_ADDRESS == `TSCU_OFS_CMD);
  assign wr_type  = acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0] &
                    (I_AVS_ADDRESS == `TSCU_OFS_CFG_TYPE);
  assign wr_limit = acc & I_AVS_WRITE & (I_AVS_ADDRESS == `TSCU_OFS_CFG_LIMIT);
  assign limit_wdata = be_merge({hi_lim_reg[cfg_chan_reg], lo_lim_reg[cfg_chan_reg]},
                                I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  assign board_rstn = I_RSTN & ~soft_rst_reg;

  // Command decode for the byte being written now
  assign do_alarm = wr_cmd & (st_reg == tscu_pkg::TSCU_ST_IDLE) &
                    (cb[7:2] == 6'(`TSCU_OP_ALARM_BASE >> 2));
  assign do_50    = wr_cmd & (st_reg == tscu_pkg::TSCU_ST_IDLE) &
                    (cb == `TSCU_OP_REJECT50);
  assign do_fast  = wr_cmd & (st_reg == tscu_pkg::TSCU_ST_EXT) & (idx_reg == 2'd1) &
                    (arg_reg == `TSCU_EXT_FAST) & (cb == `TSCU_EXT_TAIL);
  assign clr_mask = do_alarm ? (32'h0000_00ff << {cb[1:0], 3'b000}) : 32'h0000_0000;

  // Incoming sample checked against the channel's limits; disabled channels skip
  assign smp_live = I_SMP_VALID & (type_reg[I_SMP_CHAN] != `TSCU_TYPE_DISABLED);
  assign smp_up   = smp_live & ($signed(I_SMP_DATA) > hi_lim_reg[I_SMP_CHAN]);
  assign smp_lo   = smp_live & ($signed(I_SMP_DATA) < lo_lim_reg[I_SMP_CHAN]);

  // Bus handshake and read data capture
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
    begin
      wreq_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wreq_reg <= ~((I_AVS_READ | I_AVS_WRITE) & wreq_reg);
      if (rd_first)
      begin
        case (I_AVS_ADDRESS)
          `TSCU_OFS_CMD:       rdata_reg <= {23'h000000, (rsp_cnt_reg != 2'd0), rsp0_reg};
          `TSCU_OFS_STATUS:    rdata_reg <= {27'h0000000, fast_reg, mode50_reg,
                                             (st_reg != tscu_pkg::TSCU_ST_IDLE),
                                             (rsp_cnt_reg != 2'd0), alarm_reg};
          `TSCU_OFS_CFG_CHAN:  rdata_reg <= {27'h0000000, cfg_chan_reg};
          `TSCU_OFS_CFG_TYPE:  rdata_reg <= {24'h000000, type_reg[cfg_chan_reg]};
          `TSCU_OFS_CFG_LIMIT: rdata_reg <= {hi_lim_reg[cfg_chan_reg],
                                             lo_lim_reg[cfg_chan_reg]};
          default:             rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Soft board reset: a one-cycle pulse that restores every default except the configuration channel pointer and the bus handshake and read data
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0] &
                      (I_AVS_ADDRESS == `TSCU_OFS_CTRL) &
                      I_AVS_WRITEDATA[`TSCU_CTRL_SOFT_RST];
  end

  // Configuration channel pointer survives soft reset; it belongs to the bus
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RSTN)
      cfg_chan_reg <= 5'h00;
    else if (acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0] &
             (I_AVS_ADDRESS == `TSCU_OFS_CFG_CHAN))
      cfg_chan_reg <= I_AVS_WRITEDATA[4:0];
  end

  // Command sequencer and reply queue; a new opcode drops any unread reply
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      st_reg       <= tscu_pkg::TSCU_ST_IDLE;
      idx_reg      <= 2'd0;
      arg_reg      <= 8'h00;
      cal_chan_reg <= 5'h00;
      cal_span_reg <= 8'h00;
      rsp0_reg     <= 8'h00;
      rsp1_reg     <= 8'h00;
      rsp_cnt_reg  <= 2'd0;
    end
    else if (wr_cmd)
    begin
      case (st_reg)
        tscu_pkg::TSCU_ST_IDLE:
        begin
          rsp_cnt_reg <= 2'd0;
          idx_reg     <= 2'd0;
          if (do_alarm)
          begin
            // Upper byte first; bit n is channel 8*bank+n
            rsp0_reg    <= up_flag_reg[{cb[1:0], 3'b000} +: 8];
            rsp1_reg    <= lo_flag_reg[{cb[1:0], 3'b000} +: 8];
            rsp_cnt_reg <= 2'd2;
          end
          else if (cb == `TSCU_OP_EXTENDED)
            st_reg <= tscu_pkg::TSCU_ST_EXT;
          else if (cb[7:5] == 3'(`TSCU_OP_CAL_BASE >> 5))
          begin
            st_reg       <= tscu_pkg::TSCU_ST_CAL;
            cal_chan_reg <= cb[4:0];
          end
        end
        tscu_pkg::TSCU_ST_EXT:
        begin
          if (idx_reg == 2'd0)
          begin
            arg_reg <= cb;
            idx_reg <= 2'd1;
          end
          else
          begin
            st_reg  <= tscu_pkg::TSCU_ST_IDLE;
            idx_reg <= 2'd0;
            if ((arg_reg == `TSCU_EXT_VERSION) && (cb == `TSCU_EXT_TAIL))
            begin
              rsp0_reg    <= VERSION_X100[15:8];
              rsp1_reg    <= VERSION_X100[7:0];
              rsp_cnt_reg <= 2'd2;
            end
            else if ((arg_reg == `TSCU_EXT_IDENT) && (cb == `TSCU_EXT_TAIL))
            begin
              rsp0_reg    <= PRODUCT_ID[15:8];
              rsp1_reg    <= PRODUCT_ID[7:0];
              rsp_cnt_reg <= 2'd2;
            end
          end
        end
        tscu_pkg::TSCU_ST_CAL:
        begin
          case (idx_reg)
            2'd0:    cal_span_reg <= cb;
            2'd1:    arg_reg      <= cb;
            default:
            begin
              st_reg      <= tscu_pkg::TSCU_ST_IDLE;
              rsp0_reg    <= `TSCU_CAL_ACK;
              rsp_cnt_reg <= 2'd1;
            end
          endcase
          idx_reg <= (idx_reg == 2'd2) ? 2'd0 : idx_reg + 2'd1;
        end
        default:
        begin
          st_reg  <= tscu_pkg::TSCU_ST_IDLE;
          idx_reg <= 2'd0;
        end
      endcase
    end
    else if (rd_pop && (rsp_cnt_reg != 2'd0))
    begin
      rsp0_reg    <= rsp1_reg;
      rsp_cnt_reg <= rsp_cnt_reg - 2'd1;
    end
  end

  // Calibration strobe; span codes other than 0 and 1 are answered but not run
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      O_CAL_STB   <= 1'b0;
      O_CAL_CHAN  <= 5'h00;
      O_CAL_SPAN  <= tscu_pkg::TSCU_SPAN_5V;
      O_CAL_VALUE <= 16'h0000;
    end
    else
    begin
      O_CAL_STB <= 1'b0;
      if (wr_cmd && (st_reg == tscu_pkg::TSCU_ST_CAL) && (idx_reg == 2'd2) &&
          ((cal_span_reg == `TSCU_SPAN_5V) || (cal_span_reg == `TSCU_SPAN_500MV)))
      begin
        O_CAL_STB   <= 1'b1;
        O_CAL_CHAN  <= cal_chan_reg;
        O_CAL_SPAN  <= (cal_span_reg == `TSCU_SPAN_500MV) ? tscu_pkg::TSCU_SPAN_500MV
                                                          : tscu_pkg::TSCU_SPAN_5V;
        O_CAL_VALUE <= {arg_reg, cb};
      end
    end
  end

  // Mode latches: set by command, cleared only by a board reset
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      mode50_reg <= 1'b0;
      fast_reg   <= 1'b0;
    end
    else
    begin
      if (do_50)
        mode50_reg <= 1'b1;
      if (do_fast)
        fast_reg <= 1'b1;
    end
  end

  // Timing figures handed to the digitizer and scanner
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      O_MODE_50HZ    <= 1'b0;
      O_MODE_FAST    <= 1'b0;
      O_INTEG_CYCLES <= 18'(INTEG60_CYC);
      O_CHAN_CYCLES  <= 18'(CHAN_DEF_CYC);
    end
    else
    begin
      O_MODE_50HZ    <= mode50_reg;
      O_MODE_FAST    <= fast_reg;
      O_INTEG_CYCLES <= mode50_reg ? 18'(INTEG50_CYC) : 18'(INTEG60_CYC);
      O_CHAN_CYCLES  <= fast_reg ? 18'(CHAN_FAST_CYC) : 18'(CHAN_DEF_CYC);
    end
  end

  // Alarm flags: a violation in the same cycle as a readout clear wins
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      up_flag_reg <= 32'h0000_0000;
      lo_flag_reg <= 32'h0000_0000;
      alarm_reg   <= 1'b0;
    end
    else
    begin
      up_flag_reg <= (up_flag_reg & ~clr_mask) |
                     ({31'h00000000, smp_up} << I_SMP_CHAN);
      lo_flag_reg <= (lo_flag_reg & ~clr_mask) |
                     ({31'h00000000, smp_lo} << I_SMP_CHAN);
      if (smp_up | smp_lo)
        alarm_reg <= 1'b1;
      else if (do_alarm)
        alarm_reg <= 1'b0;
    end
  end

  // Per-channel type and limits; a violation rearms both limits to defaults unless a limit write to that channel lands in the same cycle
  for (genvar g = 0; g < 32; g++)
  begin : g_chan
    always_ff @(posedge I_CLK_SYS)
    begin
      if (!board_rstn)
      begin
        type_reg[g]    <= `TSCU_TYPE_RST;
        hi_lim_reg[g]  <= `TSCU_LIMIT_HI_RST;
        lo_lim_reg[g]  <= `TSCU_LIMIT_LO_RST;
        O_SCAN_MASK[g] <= 1'b1;
      end
      else
      begin
        if (wr_type && (cfg_chan_reg == 5'(g)))
          type_reg[g] <= I_AVS_WRITEDATA[7:0];
        if (wr_limit && (cfg_chan_reg == 5'(g)))
        begin
          hi_lim_reg[g] <= limit_wdata[31:16];
          lo_lim_reg[g] <= limit_wdata[15:0];
        end
        else if ((smp_up | smp_lo) && (I_SMP_CHAN == 5'(g)))
        begin
          hi_lim_reg[g] <= `TSCU_LIMIT_HI_RST;
          lo_lim_reg[g] <= `TSCU_LIMIT_LO_RST;
        end
        O_SCAN_MASK[g] <= (type_reg[g] != `TSCU_TYPE_DISABLED);
      end
    end
  end

  // Sample passed on with the scale class of its channel
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!board_rstn)
    begin
      O_SMP_VALID <= 1'b0;
      O_SMP_CHAN  <= 5'h00;
      O_SMP_DATA  <= 16'h0000;
      O_SMP_SCALE <= tscu_pkg::TSCU_SC_V500UV;
    end
    else
    begin
      O_SMP_VALID <= I_SMP_VALID;
      O_SMP_CHAN  <= I_SMP_CHAN;
      O_SMP_DATA  <= I_SMP_DATA;
      O_SMP_SCALE <= scale_of(type_reg[I_SMP_CHAN]);
    end
  end

  // Bus outputs straight from their flops
  assign O_AVS_READDATA    = rdata_reg;
  assign O_AVS_WAITREQUEST = wreq_reg;

endmodule : tscu_top

// ===== verification/tscu_sva.sv
// Port-level assertions for the thermo scanner command unit
`timescale 1ns/1ps
`include "tscu_params.svh"

module tscu_sva #(
  parameter int INTEG50_CYC   = 10,
  parameter int CHAN_FAST_CYC = 10
) (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RSTN,
  input wire logic [7:0]  I_AVS_ADDRESS,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic        I_SMP_VALID,
  input wire logic [4:0]  I_SMP_CHAN,
  input wire logic        O_SMP_VALID,
  input wire logic [4:0]  O_SMP_CHAN,
  input wire logic        O_MODE_50HZ,
  input wire logic        O_MODE_FAST,
  input wire logic [17:0] O_INTEG_CYCLES,
  input wire logic [17:0] O_CHAN_CYCLES,
  input wire logic        O_CAL_STB
);
  // Accepted soft reset; the only way besides hard reset to leave a mode
  wire soft_wr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_WRITEDATA[0]
                 && (I_AVS_ADDRESS == `TSCU_OFS_CTRL);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  // Bus request seen, then its single wait state
  sequence s_take;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence s_answer;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence
  a_one_wait: assert property (s_take |=> s_answer)
    else $error("bus answer timing wrong");
  a_fifty_sticky: assert property ($fell(O_MODE_50HZ) |->
    $past(soft_wr, 2) || $past(soft_wr, 3) || $past(soft_wr, 4))
    else $error("50 Hz mode left without reset");
  a_fast_sticky: assert property ($fell(O_MODE_FAST) |->
    $past(soft_wr, 2) || $past(soft_wr, 3) || $past(soft_wr, 4))
    else $error("fast mode left without reset");
  a_integ_fifty: assert property ($rose(O_MODE_50HZ) |->
    ##[0:2] (O_INTEG_CYCLES == 18'(INTEG50_CYC)))
    else $error("integration period not switched");
  a_chan_fast: assert property ($rose(O_MODE_FAST) |->
    ##[0:2] (O_CHAN_CYCLES == 18'(CHAN_FAST_CYC)))
    else $error("channel time not switched");
  a_cal_pulse: assert property (O_CAL_STB |=> !O_CAL_STB)
    else $error("calibration strobe too long");
  a_smp_copy: assert property (I_SMP_VALID |=> O_SMP_VALID &&
    (O_SMP_CHAN == $past(I_SMP_CHAN)))
    else $error("sample not passed on");
  a_smp_quiet: assert property (!I_SMP_VALID |=> !O_SMP_VALID)
    else $error("spurious sample");
endmodule : tscu_sva

bind tscu_top tscu_sva #(.INTEG50_CYC(INTEG50_CYC), .CHAN_FAST_CYC(CHAN_FAST_CYC)) u_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_SMP_VALID(I_SMP_VALID),
  .I_SMP_CHAN(I_SMP_CHAN), .O_SMP_VALID(O_SMP_VALID), .O_SMP_CHAN(O_SMP_CHAN),
  .O_MODE_50HZ(O_MODE_50HZ), .O_MODE_FAST(O_MODE_FAST),
  .O_INTEG_CYCLES(O_INTEG_CYCLES), .O_CHAN_CYCLES(O_CHAN_CYCLES), .O_CAL_STB(O_CAL_STB));

// ===== verification/tscu_smp_src.sv
// Scanner model that delivers scaled channel samples
`timescale 1ns/1ps

module tscu_smp_src (
  input  wire logic  i_clk,
  output logic       o_smp_valid,
  output logic [4:0] o_smp_chan,
  output logic [15:0] o_smp_data
);
  // Idle outputs before the first sample
  initial
  begin
    o_smp_valid = 1'b0;
    o_smp_chan  = 5'h00;
    o_smp_data  = 16'h0000;
  end
  // One-cycle sample; afterwards chan and data are scrambled, not held
  task automatic send(input logic [4:0] ch, input logic [15:0] d);
    @(posedge i_clk);
    o_smp_valid <= 1'b1;
    o_smp_chan  <= ch;
    o_smp_data  <= d;
    @(posedge i_clk);
    o_smp_valid <= 1'b0;
    o_smp_chan  <= ~ch;
    o_smp_data  <= ~d;
  endtask : send
endmodule : tscu_smp_src

// ===== verification/tscu_top_test.sv
// Self-checking bench for the thermo scanner command unit
`timescale 1ns/1ps
`include "tscu_params.svh"

module tscu_top_test;
  localparam logic [15:0] VER = 16'h0123;
  localparam logic [15:0] PID = 16'h3c96; // Arbitrary identifier value
  localparam int I60 = 10, I50 = 12, CDEF = 20, CFST = 8;
  localparam logic [7:0] CMD = `TSCU_OFS_CMD, STA = `TSCU_OFS_STATUS, CHN = `TSCU_OFS_CFG_CHAN;
  localparam logic [7:0] TYP = `TSCU_OFS_CFG_TYPE, LIM = `TSCU_OFS_CFG_LIMIT;
  localparam logic [7:0] CTL = `TSCU_OFS_CTRL;
  logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, mask;
  logic        wq, sv, sval, m50, mf, cstb, cspan;
  logic [4:0]  sc, cch;
  logic [15:0] sd, cval, sdo;
  logic [17:0] ic, cc;
  logic [2:0]  sscl;
  int          bad_count = 0, checks = 0;
  logic [7:0]  tcode [15] = '{8'h17, 8'h16, 8'h15, 8'h00, 8'h24, 8'h23, 8'h01, 8'h1b,
                              8'h1c, 8'h22, 8'h1d, 8'h1e, 8'h1f, 8'h11, 8'h13};
  logic [2:0]  tscl [15] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4,
                             3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6};

  tscu_top #(.VERSION_X100(VER), .PRODUCT_ID(PID), .INTEG60_CYC(I60), .INTEG50_CYC(I50),
    .CHAN_DEF_CYC(CDEF), .CHAN_FAST_CYC(CFST)) DUT (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq), .I_SMP_VALID(sv), .I_SMP_CHAN(sc),
    .I_SMP_DATA(sd), .O_SMP_VALID(sval), .O_SMP_CHAN(), .O_SMP_DATA(sdo), .O_SMP_SCALE(sscl),
    .O_SCAN_MASK(mask), .O_MODE_50HZ(m50), .O_MODE_FAST(mf), .O_INTEG_CYCLES(ic),
    .O_CHAN_CYCLES(cc), .O_CAL_STB(cstb), .O_CAL_CHAN(cch), .O_CAL_SPAN(cspan),
    .O_CAL_VALUE(cval));
  tscu_smp_src SRC (.i_clk(clk), .o_smp_valid(sv), .o_smp_chan(sc), .o_smp_data(sd));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus access; held until waitrequest is sampled low, the watchdog bounds the wait
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, a, d, x);
  endtask : w

  task automatic cmd(input logic [7:0] b);
    w(CMD, {24'h0, b});
  endtask : cmd

  task automatic ext(input logic [7:0] b);
    cmd(`TSCU_OP_EXTENDED);
    cmd(b);
    cmd(8'h00);
  endtask : ext

  // Pops one reply byte and checks its value
  task automatic rsp(input logic [7:0] b);
    logic [31:0] q;
    acc(1'b0, CMD, 32'h0, q);
    chk("reply", q, {23'h0, 1'b1, b});
  endtask : rsp

  task automatic t_defaults;
    logic [31:0] q;
    acc(1'b0, STA, 32'h0, q);
    chk("status", q[4:0], 32'h0);
    chk("integ", ic, I60);
    chk("chan_t", cc, CDEF);
    chk("mask", mask, 32'hffffffff);
  endtask : t_defaults

  task automatic t_alarm;
    logic [31:0] q;
    w(CHN, 32'ha);
    w(LIM, 32'h0064ff9c);
    w(CHN, 32'hd);
    w(LIM, 32'h0064ff9c);
    SRC.send(5'd10, 16'h00c8);
    SRC.send(5'd13, 16'hff38);
    acc(1'b0, STA, 32'h0, q);
    chk("alarm", q[0], 1);
    cmd(8'h6d);
    rsp(8'h04);
    rsp(8'h20);
    acc(1'b0, STA, 32'h0, q);
    chk("alarm_clr", q[1:0], 0);
    cmd(8'h6d);
    rsp(8'h00);
    rsp(8'h00);
  endtask : t_alarm

  // Every sensor code against its scale, then the disabled mask
  task automatic t_scale;
    w(CHN, 32'h3);
    for (int i = 0; i < 15; i++)
    begin
      w(TYP, {24'h0, tcode[i]});
      SRC.send(5'd3, 16'h0010);
      #1;
      chk("scale", sscl, tscl[i]);
      chk("data", sdo, 32'h0010);
    end
    chk("mask3", mask[3], 0);
  endtask : t_scale

  task automatic t_modes;
    logic [31:0] q;
    cmd(`TSCU_OP_REJECT50);
    ext(`TSCU_EXT_FAST);
    repeat (3) @(posedge clk);
    #1;
    chk("m50", m50, 1);
    chk("fast", mf, 1);
    chk("integ", ic, I50);
    chk("chan_t", cc, CFST);
    acc(1'b0, STA, 32'h0, q);
    chk("status", q[4:0], 32'h18);
    w(CTL, 32'h1);
    repeat (4) @(posedge clk);
    #1;
    chk("m50", m50, 0);
    chk("fast", mf, 0);
    chk("integ", ic, I60);
    chk("chan_t", cc, CDEF);
    SRC.send(5'd3, 16'h0000);
    #1;
    chk("scale", sscl, 3'h3);
  endtask : t_modes

  task automatic t_ident;
    ext(`TSCU_EXT_VERSION);
    rsp(VER[15:8]);
    rsp(VER[7:0]);
    ext(`TSCU_EXT_IDENT);
    rsp(PID[15:8]);
    rsp(PID[7:0]);
  endtask : t_ident

  // Spans 0 and 1 strobe; span 2 is answered and leaves the outputs at reset values
  task automatic t_cal;
    for (int s = 0; s < 3; s++)
    begin
      w(CHN, 32'h7);
      w(TYP, (s == 1) ? 32'h16 : 32'h15);
      repeat (5) @(posedge clk); // Let the reference settle
      cmd(8'hc7);
      cmd(8'(s));
      cmd(8'h12);
      cmd(8'h34);
      #1; // Strobe stands only in the cycle after the accepting edge
      chk("cal_stb", cstb, s < 2);
      chk("cal_span", cspan, s == 1);
      chk("cal_ch", {cch, cval}, (s < 2) ? 21'h71234 : 21'h0);
      rsp(`TSCU_CAL_ACK);
      w(CTL, 32'h1); // Board reset after each span
    end
  endtask : t_cal

  task automatic print_verdict;
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence; a hard reset in 50 Hz mode closes the run
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_defaults;
    t_alarm;
    t_scale;
    t_modes;
    t_ident;
    t_cal;
    cmd(`TSCU_OP_REJECT50);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_defaults;
    print_verdict;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #2000000;
    bad_count++;
    print_verdict;
  end
endmodule : tscu_top_test
